/* File: verilog/async_serial_port_zero_pkg.sv */
// How it works
// RULE1: Divisor is two high bits plus low byte.
// RULE2: Zero divisor stops the baud clock entirely.
// RULE3: Bit rate is bus clock over sixteen-times divisor.
// RULE4: Format bit 6 switches whole module on.
// RULE5: Format bit 5 switches receiver on, transmit unaffected.
// RULE6: Format bit 4 enables multiprocessor address mode.
// RULE7: Format bit 3 picks two or one stops.
// RULE8: Format bit 2 picks nine or eight bits.
// RULE9: Format bit 1 enables parity generate and check.
// RULE10: Format bit 0 picks odd or even parity.
// RULE11: Control bits 3 and 2 gate interrupt requests.
// RULE12: Status bit 6 shows received ninth bit.
// RULE13: Status bit 5 holds sent ninth bit.
// RULE14: Status bit 4 flags send buffer empty.
// RULE15: Status bit 3 flags receive buffer full.
// RULE16: Status bit 2 flags overrun, new data dropped.
// RULE17: Status bit 1 flags framing error.
// RULE18: Status bit 0 flags parity mismatch.
// RULE19: Data register reads receive, writes send buffer.
// RULE20: Low start, LSB first, ninth bit, high stops.
// RULE21: Sample bit centres; low stop is framing error.
package async_serial_port_zero_pkg;

    localparam int ADDR_W = 10;
    localparam logic [7:0] IDX_BAUD_LOW = 8'hbd;
    localparam logic [7:0] IDX_FORMAT = 8'hbe;
    localparam logic [7:0] IDX_IRQ_DIV_HIGH = 8'hbf;
    localparam logic [7:0] IDX_STATUS = 8'hc0;
    localparam logic [7:0] IDX_DATA = 8'hc1;
    localparam logic [23:0] READ_PAD = 24'h00_0000;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    localparam int FMT_MODULE_ON = 6;
    localparam int FMT_RECV_ON = 5;
    localparam int FMT_MULTI = 4;
    localparam int FMT_STOP2 = 3;
    localparam int FMT_DATA9 = 2;
    localparam int FMT_PARITY_ON = 1;
    localparam int FMT_PARITY_ODD = 0;
    localparam logic [7:0] FMT_WRITE_MASK = 8'h7f;

    localparam int CTL2_SEND_IE = 3;
    localparam int CTL2_RECV_IE = 2;
    localparam int CTL2_DIV_HI_MSB = 1;
    localparam int CTL2_DIV_HI_LSB = 0;
    localparam logic [7:0] CTL2_WRITE_MASK = 8'h0f;

    localparam int ST_RECV_NINTH = 6;
    localparam int ST_SEND_NINTH = 5;
    localparam int ST_SEND_EMPTY = 4;
    localparam int ST_RECV_FULL = 3;
    localparam int ST_OVERFLOW = 2;
    localparam int ST_FRAME_ERR = 1;
    localparam int ST_PARITY_ERR = 0;

    localparam logic [7:0] RESET_BAUD_LOW = 8'h00;
    localparam logic [7:0] RESET_FORMAT = 8'h00;
    localparam logic [7:0] RESET_IRQ_DIV_HIGH = 8'h0c;
    localparam logic [7:0] RESET_DATA = 8'hff;

    localparam logic [9:0] BAUD_DIV_OFF = 10'h000;
    localparam logic [9:0] BAUD_STEP = 10'h001;
    localparam logic [3:0] TICK_LAST = 4'hf;
    localparam logic [3:0] TICK_MID_START = 4'h7;
    localparam logic [3:0] DATA_BITS = 4'h8;

    typedef enum logic [1:0] {TX_IDLE = 2'h1, TX_SHIFT = 2'h2} tx_state_t;
    typedef enum logic [2:0] {RX_IDLE = 3'h1, RX_START = 3'h2, RX_BITS = 3'h4} rx_state_t;

    typedef struct packed {
        logic ack;
        logic [7:0] rdata;
        logic [7:0] div_lo;
        logic [7:0] fmt;
        logic [7:0] ctl2;
        logic recv_ninth_bit;
        logic send_ninth_bit;
        logic send_empty;
        logic recv_full;
        logic overflow;
        logic frame_err;
        logic parity_err;
        logic [7:0] send_buf;
        logic send_full;
        logic [7:0] recv_buf;
        logic [9:0] baud_cnt;
        tx_state_t tx_state;
        logic [11:0] tx_sh;
        logic [3:0] tx_tick;
        logic [3:0] tx_bitn;
        logic txd;
        rx_state_t rx_state;
        logic [10:0] rx_sh;
        logic [3:0] rx_tick;
        logic [3:0] rx_bitn;
        logic rx_ferr;
        logic rx_done;
        logic sync1;
        logic sync2;
        logic sync3;
        logic rx_level;
    } port_state_t;

endpackage : async_serial_port_zero_pkg

/* File: verilog/async_serial_port_zero.sv */
`timescale 1ns/100ps
`default_nettype none
module async_serial_port_zero
    import async_serial_port_zero_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    input wire logic [ADDR_W-1:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    input wire logic i_rxd,
    output logic o_txd,
    output logic o_send_irq_req,
    output logic o_recv_irq_req
);

    localparam port_state_t STATE_RESET = '{
        ack: 1'b0,
        rdata: UNMAPPED_READ,
        div_lo: RESET_BAUD_LOW,
        fmt: RESET_FORMAT,
        ctl2: RESET_IRQ_DIV_HIGH,
        recv_ninth_bit: 1'b0,
        send_ninth_bit: 1'b0,
        send_empty: 1'b0,
        recv_full: 1'b0,
        overflow: 1'b0,
        frame_err: 1'b0,
        parity_err: 1'b0,
        send_buf: RESET_DATA,
        send_full: 1'b0,
        recv_buf: RESET_DATA,
        baud_cnt: BAUD_DIV_OFF,
        tx_state: TX_IDLE,
        tx_sh: 12'hfff,
        tx_tick: 4'h0,
        tx_bitn: 4'h0,
        txd: 1'b1,
        rx_state: RX_IDLE,
        rx_sh: 11'h7ff,
        rx_tick: 4'h0,
        rx_bitn: 4'h0,
        rx_ferr: 1'b0,
        rx_done: 1'b0,
        sync1: 1'b1,
        sync2: 1'b1,
        sync3: 1'b1,
        rx_level: 1'b1
    };

    port_state_t st_reg;
    port_state_t st_next;

    // Parity bit that makes the ones count even, or odd when asked.
    function automatic logic calc_parity(input logic [7:0] data, input logic odd);
        calc_parity = (^data) ^ odd;
    endfunction : calc_parity

    // Number of bit times that follow the start bit.
    function automatic logic [3:0] frame_len(input logic [7:0] fmt);
        logic extra;
        extra = fmt[FMT_DATA9] | fmt[FMT_PARITY_ON];
        frame_len = DATA_BITS + {3'h0, extra} + (fmt[FMT_STOP2] ? 4'h2 : 4'h1);
    endfunction : frame_len

    logic bus_req;
    logic bus_take;
    logic wr_byte;
    logic [7:0] reg_idx;
    logic [7:0] wdata;
    logic module_on;
    logic rx_run;
    logic parity_on;
    logic extra_bit;
    logic [9:0] divisor;
    logic baud_tick;

    assign bus_req = i_avs_read | i_avs_write;
    assign bus_take = bus_req & st_reg.ack;
    assign reg_idx = i_avs_address[ADDR_W-1:2];
    assign wdata = i_avs_writedata[7:0];
    assign wr_byte = i_avs_write & bus_take & i_avs_byteenable[0];
    assign module_on = st_reg.fmt[FMT_MODULE_ON]; // RULE4
    assign rx_run = module_on & st_reg.fmt[FMT_RECV_ON]; // RULE5
    assign parity_on = st_reg.fmt[FMT_PARITY_ON]; // RULE9
    assign extra_bit = st_reg.fmt[FMT_DATA9] | parity_on; // RULE8
    assign divisor = {st_reg.ctl2[CTL2_DIV_HI_MSB:CTL2_DIV_HI_LSB], st_reg.div_lo}; // RULE1
    // Sixteen ticks per bit, one tick every divisor bus clocks; none at zero.
    assign baud_tick = module_on && (divisor != BAUD_DIV_OFF) && (st_reg.baud_cnt >= divisor - BAUD_STEP); // RULE2 RULE3

    assign o_avs_waitrequest = bus_req & ~st_reg.ack;
    assign o_avs_readdata = {READ_PAD, st_reg.rdata};
    assign o_txd = st_reg.txd;
    assign o_send_irq_req = st_reg.ctl2[CTL2_SEND_IE] & st_reg.send_empty; // RULE11
    assign o_recv_irq_req = st_reg.ctl2[CTL2_RECV_IE] & st_reg.recv_full; // RULE11

    always_comb
    begin
        logic ninth;
        logic accept;
        logic [3:0] flen;
        ninth = 1'b0;
        accept = 1'b0;
        flen = frame_len(st_reg.fmt);
        st_next = st_reg;

        // Bus slave: one wait cycle, read data latched before release.
        st_next.ack = bus_req & ~st_reg.ack;
        if (bus_req && !st_reg.ack)
        begin
            case (reg_idx)
                IDX_BAUD_LOW: st_next.rdata = st_reg.div_lo;
                IDX_FORMAT: st_next.rdata = st_reg.fmt;
                IDX_IRQ_DIV_HIGH: st_next.rdata = st_reg.ctl2;
                IDX_STATUS: st_next.rdata = {1'b0, st_reg.recv_ninth_bit, st_reg.send_ninth_bit,
                    st_reg.send_empty, st_reg.recv_full, st_reg.overflow, st_reg.frame_err,
                    st_reg.parity_err}; // RULE12
                IDX_DATA: st_next.rdata = st_reg.recv_buf; // RULE19
                default: st_next.rdata = UNMAPPED_READ;
            endcase
        end

        if (wr_byte)
        begin
            case (reg_idx)
                IDX_BAUD_LOW: st_next.div_lo = wdata;
                IDX_FORMAT: st_next.fmt = wdata & FMT_WRITE_MASK;
                IDX_IRQ_DIV_HIGH: st_next.ctl2 = wdata & CTL2_WRITE_MASK;
                IDX_STATUS:
                begin
                    // Writing zero clears a flag, writing one keeps it.
                    st_next.send_empty = st_reg.send_empty & wdata[ST_SEND_EMPTY]; // RULE14
                    st_next.recv_full = st_reg.recv_full & wdata[ST_RECV_FULL]; // RULE15
                    st_next.overflow = st_reg.overflow & wdata[ST_OVERFLOW]; // RULE16
                    st_next.frame_err = st_reg.frame_err & wdata[ST_FRAME_ERR]; // RULE17
                    st_next.parity_err = st_reg.parity_err & wdata[ST_PARITY_ERR]; // RULE18
                    if (!parity_on)
                    begin
                        st_next.send_ninth_bit = wdata[ST_SEND_NINTH]; // RULE13
                    end
                end
                default:
                begin
                end
            endcase
        end

        // Baud counter.
        if (!module_on || baud_tick)
        begin
            st_next.baud_cnt = BAUD_DIV_OFF;
        end
        else
        begin
            st_next.baud_cnt = st_reg.baud_cnt + BAUD_STEP;
        end

        // Transmitter.
        case (st_reg.tx_state)
            TX_IDLE:
            begin
                st_next.txd = 1'b1; // RULE20
                if (module_on && st_reg.send_full && baud_tick)
                begin
                    if (parity_on)
                    begin
                        ninth = calc_parity(st_reg.send_buf, st_reg.fmt[FMT_PARITY_ODD]); // RULE9 RULE10
                        st_next.send_ninth_bit = ninth; // RULE13
                    end
                    else
                    begin
                        ninth = st_reg.send_ninth_bit;
                    end
                    if (extra_bit)
                    begin
                        st_next.tx_sh = {2'h3, ninth, st_reg.send_buf, 1'b0}; // RULE8 RULE20
                    end
                    else
                    begin
                        st_next.tx_sh = {3'h7, st_reg.send_buf, 1'b0}; // RULE20
                    end
                    st_next.txd = 1'b0;
                    st_next.tx_tick = 4'h0;
                    st_next.tx_bitn = 4'h0;
                    st_next.tx_state = TX_SHIFT;
                    st_next.send_full = 1'b0;
                    st_next.send_empty = 1'b1; // RULE14
                end
            end
            TX_SHIFT:
            begin
                if (baud_tick)
                begin
                    st_next.tx_tick = st_reg.tx_tick + 4'h1;
                    if (st_reg.tx_tick == TICK_LAST)
                    begin
                        st_next.tx_sh = {1'b1, st_reg.tx_sh[11:1]};
                        st_next.tx_bitn = st_reg.tx_bitn + 4'h1;
                        if (st_reg.tx_bitn == flen)
                        begin
                            st_next.tx_state = TX_IDLE; // RULE7
                            st_next.txd = 1'b1;
                        end
                        else
                        begin
                            st_next.txd = st_reg.tx_sh[1];
                        end
                    end
                end
            end
            default:
            begin
                st_next.tx_state = TX_IDLE;
                st_next.txd = 1'b1;
            end
        endcase
        if (!module_on)
        begin
            st_next.tx_state = TX_IDLE; // RULE4
            st_next.txd = 1'b1;
        end

        // Receive line synchroniser and filter.
        st_next.sync1 = i_rxd;
        st_next.sync2 = st_reg.sync1;
        st_next.sync3 = st_reg.sync2;
        if (st_reg.sync2 == st_reg.sync3)
        begin
            st_next.rx_level = st_reg.sync3;
        end

        // Receiver.
        st_next.rx_done = 1'b0;
        case (st_reg.rx_state)
            RX_IDLE:
            begin
                if (!st_reg.rx_level)
                begin
                    st_next.rx_state = RX_START;
                    st_next.rx_tick = 4'h0;
                end
            end
            RX_START:
            begin
                if (baud_tick)
                begin
                    st_next.rx_tick = st_reg.rx_tick + 4'h1;
                    if (st_reg.rx_tick == TICK_MID_START)
                    begin
                        st_next.rx_tick = 4'h0;
                        st_next.rx_bitn = 4'h0;
                        st_next.rx_ferr = 1'b0;
                        st_next.rx_state = st_reg.rx_level ? RX_IDLE : RX_BITS; // RULE21
                    end
                end
            end
            RX_BITS:
            begin
                if (baud_tick)
                begin
                    st_next.rx_tick = st_reg.rx_tick + 4'h1;
                    if (st_reg.rx_tick == TICK_LAST)
                    begin
                        st_next.rx_sh[st_reg.rx_bitn] = st_reg.rx_level; // RULE20 RULE21
                        if (st_reg.rx_bitn >= DATA_BITS + {3'h0, extra_bit} && !st_reg.rx_level)
                        begin
                            st_next.rx_ferr = 1'b1; // RULE21
                        end
                        st_next.rx_bitn = st_reg.rx_bitn + 4'h1;
                        if (st_reg.rx_bitn == flen - 4'h1)
                        begin
                            st_next.rx_state = RX_IDLE; // RULE7
                            st_next.rx_done = 1'b1;
                        end
                    end
                end
            end
            default:
            begin
                st_next.rx_state = RX_IDLE;
            end
        endcase
        if (!rx_run)
        begin
            st_next.rx_state = RX_IDLE; // RULE5
            st_next.rx_done = 1'b0;
        end

        // Deliver a finished frame; hardware sets win over clearing writes.
        if (st_reg.rx_done)
        begin
            ninth = extra_bit & st_reg.rx_sh[8];
            accept = !(st_reg.fmt[FMT_MULTI] && st_reg.fmt[FMT_DATA9] && !parity_on && !ninth); // RULE6
            if (accept)
            begin
                if (st_reg.recv_full)
                begin
                    st_next.overflow = 1'b1; // RULE16
                end
                else
                begin
                    st_next.recv_buf = st_reg.rx_sh[7:0]; // RULE19
                    st_next.recv_ninth_bit = ninth; // RULE12
                    st_next.recv_full = 1'b1; // RULE15
                end
                if (st_reg.rx_ferr)
                begin
                    st_next.frame_err = 1'b1; // RULE17
                end
                if (parity_on && (ninth != calc_parity(st_reg.rx_sh[7:0], st_reg.fmt[FMT_PARITY_ODD])))
                begin
                    st_next.parity_err = 1'b1; // RULE18 RULE10
                end
            end
        end

        // A data write refills the send buffer, so it is no longer empty.
        if (wr_byte && reg_idx == IDX_DATA)
        begin
            st_next.send_buf = wdata; // RULE19
            st_next.send_full = 1'b1;
            st_next.send_empty = 1'b0;
        end
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (i_sys_rst)
        begin
            st_reg <= STATE_RESET;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (i_sys_rst);

    chk_zero_div_quiet: assert property (divisor == BAUD_DIV_OFF |-> !baud_tick) // RULE2
        else $error("baud tick with zero divisor");

    // A divisor write right after a tick may legally bring the next tick forward.
    chk_tick_spacing: assert property ((baud_tick && divisor > BAUD_STEP && $stable(divisor)) // RULE3
        |=> !baud_tick || $changed(divisor))
        else $error("baud ticks too close");

    chk_tx_idle_high: assert property (st_reg.tx_state == TX_IDLE |-> o_txd) // RULE20
        else $error("line not high while idle");

    chk_tx_start_low: assert property ($rose(st_reg.tx_state == TX_SHIFT) |-> !o_txd) // RULE20
        else $error("frame did not start low");

    chk_module_off_idle: assert property (!module_on |=> st_reg.tx_state == TX_IDLE && st_reg.rx_state == RX_IDLE) // RULE4
        else $error("engines run with module off");

    chk_recv_off_idle: assert property (!st_reg.fmt[FMT_RECV_ON] |=> st_reg.rx_state == RX_IDLE) // RULE5
        else $error("receiver runs while off");

    // A frame dropped in address mode is not received, so it cannot overrun.
    chk_overrun_keeps_data: assert property ((st_reg.rx_done && st_reg.recv_full // RULE16
        && !(st_reg.fmt[FMT_MULTI] && st_reg.fmt[FMT_DATA9] && !parity_on && !st_reg.rx_sh[8]))
        |=> $stable(st_reg.recv_buf) && st_reg.overflow)
        else $error("overrun overwrote receive data");

    chk_irq_gate: assert property (!st_reg.ctl2[CTL2_SEND_IE] |-> !o_send_irq_req) // RULE11
        else $error("send request not gated");

    chk_write_one_keeps: assert property ((wr_byte && reg_idx == IDX_STATUS && wdata[ST_FRAME_ERR] // RULE17
        && st_reg.frame_err) |=> st_reg.frame_err)
        else $error("writing one cleared framing flag");

    chk_send_load_empty: assert property ((st_reg.tx_state == TX_IDLE && st_reg.send_full && baud_tick // RULE14
        && module_on && !(wr_byte && reg_idx == IDX_DATA)) |=> st_reg.send_empty && !st_reg.send_full)
        else $error("send empty flag not set on load");

    chk_bus_answer: assert property ((bus_req && !st_reg.ack) |=> !o_avs_waitrequest || !bus_req)
        else $error("bus answer late");

endmodule : async_serial_port_zero
`default_nettype wire

/* File: sim/serial_line_partner.sv */
`timescale 1ns/100ps
`default_nettype none
module serial_line_partner
(
    input wire logic i_clk,
    input wire logic i_line,
    output logic o_line
);
    initial o_line = 1'b1;
    // Sends bit 0 of f first, each bit held for bt clocks, then idles high.
    task automatic send(input logic [11:0] f, input int n, input int bt);
        for (int k = 0; k < n; k++)
        begin
            @(posedge i_clk) o_line <= f[k];
            repeat (bt - 1) @(posedge i_clk);
        end
        @(posedge i_clk) o_line <= 1'b1;
    endtask : send
    // Waits for a start edge, then samples n bit centres.
    task automatic get_frame(input int n, input int bt, output logic [11:0] f);
        int w;
        f = '1;
        w = 0;
        while (i_line !== 1'b0 && w < 5000)
        begin
            @(posedge i_clk);
            w++;
        end
        repeat (bt / 2) @(posedge i_clk);
        f[0] = i_line;
        for (int k = 1; k < n; k++)
        begin
            repeat (bt) @(posedge i_clk);
            f[k] = i_line;
        end
    endtask : get_frame
endmodule : serial_line_partner
`default_nettype wire

/* File: sim/async_serial_port_zero_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module async_serial_port_zero_tb;
    import async_serial_port_zero_pkg::*;
    logic clk, rst, rd, wr, rxd, txd, sirq, rirq, wreq;
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdat, rdat;
    logic [3:0] be;
    logic [7:0] seed, x, s, e, m;
    logic [11:0] fr, got;
    logic [7:0] rxq[$];
    int error_cnt, compares, n, bt;
    logic [7:0] idx_t[6] = '{IDX_BAUD_LOW, IDX_FORMAT, IDX_IRQ_DIV_HIGH, IDX_STATUS, IDX_DATA, 8'h10};
    logic [7:0] rst_t[6] = '{8'h00, 8'h00, 8'h0c, 8'h00, 8'hff, 8'h00};

    async_serial_port_zero dut (.i_sys_clk(clk), .i_sys_rst(rst), .i_avs_address(addr),
        .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdat), .i_avs_byteenable(be),
        .o_avs_readdata(rdat), .o_avs_waitrequest(wreq), .i_rxd(rxd), .o_txd(txd),
        .o_send_irq_req(sirq), .o_recv_irq_req(rirq));
    serial_line_partner far (.i_clk(clk), .i_line(txd), .o_line(rxd));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic stop_test;
        $display("errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0)
        begin
            $display("*** PASS ***");
        end
        else
        begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] g);
        compares++;
        if (g !== ex)
        begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", nm, ex, g);
        end
    endtask : chk

    task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] wd, output logic [7:0] r);
        int t;
        @(posedge clk);
        addr <= {idx, 2'b00};
        rd <= ~w;
        wr <= w;
        wdat <= {24'h00_0000, wd};
        t = 0;
        do
        begin
            @(posedge clk);
            t++;
        end
        while (wreq !== 1'b0 && t < 50);
        r = rdat[7:0];
        rd <= 1'b0;
        wr <= 1'b0;
        if (t >= 50)
        begin
            error_cnt++;
            stop_test();
        end
    endtask : bus

    task automatic w8(input logic [7:0] idx, input logic [7:0] v);
        logic [7:0] r;
        bus(1'b1, idx, v, r);
    endtask : w8

    task automatic rchk(input string nm, input logic [7:0] idx, input logic [7:0] mk_, input logic [7:0] ex);
        logic [7:0] r;
        bus(1'b0, idx, 8'h00, r);
        chk(nm, ex, r & mk_);
    endtask : rchk

    function automatic logic [7:0] lfsr(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction : lfsr

    // Builds a frame from c = {stop2, data9, parity_on, odd}; bit 0 is the start bit.
    function automatic logic [11:0] mk(input logic [3:0] c, input logic [7:0] d, input logic t8, output int nb);
        logic p;
        p = c[1] ? (^d ^ c[0]) : t8;
        nb = 10 + int'(c[2] | c[1]) + int'(c[3]);
        mk = (c[2] | c[1]) ? {2'b11, p, d, 1'b0} : {3'b111, d, 1'b0};
    endfunction : mk

    task automatic rx(input logic [3:0] c, input logic [7:0] d, input logic t8, input logic [11:0] fl);
        fr = mk(c, d, t8, n);
        far.send(fr ^ fl, n, 16);
        repeat (8) @(posedge clk);
        bus(1'b0, IDX_STATUS, 8'h00, s);
    endtask : rx

    initial
    begin
        repeat (90000) @(posedge clk);
        error_cnt++;
        stop_test();
    end

    initial
    begin
        rst = 1'b1;
        rd = 1'b0;
        wr = 1'b0;
        addr = '0;
        wdat = '0;
        be = 4'hf;
        seed = 8'h2b;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        for (int k = 0; k < 6; k++) rchk("reset value", idx_t[k], 8'hff, rst_t[k]);
        chk("irq after reset", 0, {sirq, rirq});
        w8(IDX_FORMAT, 8'hff);
        rchk("format mask", IDX_FORMAT, 8'hff, 8'h7f);
        w8(IDX_IRQ_DIV_HIGH, 8'hf8);
        rchk("ctl2 mask", IDX_IRQ_DIV_HIGH, 8'hff, 8'h08);
        be <= 4'he;
        w8(IDX_BAUD_LOW, 8'h55);
        be <= 4'hf;
        w8(8'h10, 8'haa);
        rchk("masked write", IDX_BAUD_LOW, 8'hff, 8'h00);
        rchk("unmapped", 8'h10, 8'hff, 8'h00);
        for (int i = 0; i < 16; i++)
        begin
            seed = lfsr(seed);
            bt = 16 * (i % 2 + 1);
            w8(IDX_BAUD_LOW, 8'(i % 2 + 1));
            w8(IDX_FORMAT, 8'h40 | 8'(i));
            w8(IDX_STATUS, {2'b00, seed[7], 5'h00});
            fr = mk(4'(i), seed, seed[7], n);
            fork
                far.get_frame(n, bt, got);
                w8(IDX_DATA, seed);
            join
            chk("tx frame", fr, got);
            repeat (bt * 2) @(posedge clk);
            x = {2'b00, (i % 4 > 1) ? fr[9] : seed[7], 5'h10};
            rchk("tx status", IDX_STATUS, 8'hff, x);
            chk("send irq", 1, sirq);
        end
        w8(IDX_IRQ_DIV_HIGH, 8'h04);
        @(posedge clk);
        chk("send irq off", 0, sirq);
        w8(IDX_IRQ_DIV_HIGH, 8'h09);
        w8(IDX_BAUD_LOW, 8'h00);
        w8(IDX_DATA, 8'h04);
        n = 0;
        while (txd !== 1'b0 && n < 9000)
        begin
            @(posedge clk);
            n++;
        end
        while (txd !== 1'b1 && n < 30000)
        begin
            @(posedge clk);
            n++;
        end
        n = 0;
        while (txd === 1'b1 && n < 9000)
        begin
            @(posedge clk);
            n++;
        end
        chk("bit time", 4096, n);
        w8(IDX_FORMAT, 8'h00);
        w8(IDX_IRQ_DIV_HIGH, 8'h0c);
        for (int k = 0; k < 2; k++)
        begin
            w8(IDX_BAUD_LOW, k ? 8'h00 : 8'h01);
            w8(IDX_FORMAT, k ? 8'h40 : 8'h00);
            w8(IDX_DATA, 8'h00);
            n = 0;
            repeat (400) @(posedge clk) if (txd !== 1'b1) n++;
            chk("quiet line", 0, n);
        end
        w8(IDX_BAUD_LOW, 8'h01);
        for (int i = 0; i < 16; i++)
        begin
            seed = lfsr(seed);
            w8(IDX_FORMAT, 8'h60 | 8'(i));
            w8(IDX_STATUS, 8'h00);
            rxq.push_back(seed);
            rx(4'(i), seed, seed[0], 12'h000);
            m = (i % 8 > 1) ? 8'h4f : 8'h0f;
            e = 8'h08 | ((i % 8 > 1) ? {1'b0, fr[9], 6'h00} : 8'h00);
            chk("rx status", e, s & m);
            rchk("rx data", IDX_DATA, 8'hff, rxq.pop_front());
            chk("recv irq", 1, rirq);
        end
        w8(IDX_FORMAT, 8'h62);
        w8(IDX_STATUS, 8'h00);
        rx(4'h2, 8'h3c, 1'b0, 12'h200);
        chk("parity err", 8'h09, s & 8'h0f);
        w8(IDX_STATUS, 8'hff);
        rchk("write one", IDX_STATUS, 8'h0f, 8'h09);
        w8(IDX_STATUS, 8'h00);
        rchk("write zero", IDX_STATUS, 8'h0f, 8'h00);
        w8(IDX_FORMAT, 8'h60);
        rx(4'h0, 8'h81, 1'b0, 12'h200);
        chk("frame err", 8'h02, s & 8'h02);
        w8(IDX_STATUS, 8'h00);
        rx(4'h0, 8'ha5, 1'b0, 12'h000);
        rx(4'h0, 8'h5a, 1'b0, 12'h000);
        chk("overflow", 8'h0c, s & 8'h0f);
        rchk("kept data", IDX_DATA, 8'hff, 8'ha5);
        w8(IDX_STATUS, 8'h00);
        rchk("overflow clr", IDX_STATUS, 8'h0f, 8'h00);
        w8(IDX_FORMAT, 8'h40);
        rx(4'h0, 8'h11, 1'b0, 12'h000);
        chk("receiver off", 8'h00, s & 8'h0f);
        w8(IDX_FORMAT, 8'h74);
        rx(4'h4, 8'h22, 1'b0, 12'h000);
        chk("mp dropped", 8'h00, s & 8'h0f);
        rx(4'h4, 8'h33, 1'b1, 12'h000);
        chk("mp taken", 8'h48, s & 8'h4f);
        rchk("mp data", IDX_DATA, 8'hff, 8'h33);
        stop_test();
    end
endmodule : async_serial_port_zero_tb
`default_nettype wire
